// [src/sram_host_regs.svh]
`ifndef SRAM_HOST_REGS_SVH
`define SRAM_HOST_REGS_SVH

// clock period in picoseconds (100 MHz)
`define SRAM_CLK_PERIOD_PS 10000
// slow grade figures in picoseconds, covering both grades
`define SRAM_T_CYCLE_PS 7000
`define SRAM_T_WRITE_PULSE_PS 7000
`define SRAM_T_DATA_SETUP_PS 3500
`define SRAM_T_ACCESS_PS 7000
`define SRAM_T_RELEASE_PS 3500
`define SRAM_T_WRITE_RECOVERY_PS 1000
// least times round up to whole cycles
`define SRAM_CYC(ps) ((((ps) + `SRAM_CLK_PERIOD_PS - 1) / `SRAM_CLK_PERIOD_PS) < 1 ? 1 : \
    (((ps) + `SRAM_CLK_PERIOD_PS - 1) / `SRAM_CLK_PERIOD_PS))
`define SRAM_WRITE_CYCLES `SRAM_CYC(`SRAM_T_WRITE_PULSE_PS)
`define SRAM_READ_CYCLES (`SRAM_CYC(`SRAM_T_ACCESS_PS) + 1)
`define SRAM_TURN_CYCLES `SRAM_CYC(`SRAM_T_RELEASE_PS)
// reset value of the select and strobe pins
`define SRAM_PIN_IDLE 1'b1
`define SRAM_ADDR_W 17
`define SRAM_DATA_W 8

`endif

// [src/sram_host_pkg.sv]
package sram_host_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE,
        ST_HOLD,
        ST_TURN
    } state_e;
endpackage : sram_host_pkg

// [src/sram_host.sv]
// Notes on behaviour
// - write strobe stays high throughout every read cycle
// - read address held stable at least one full cycle time
// - address is valid no later than select falling in reads
// - write address set on the same edge as strobe falls, pulse long enough, held after
// - write data set up before the write window ends, held after
// - select-ended write: address set on the same edge as select falls, select held long enough
// - each write cycle lasts at least one full cycle time
// - host and memory never drive the data bus together
`timescale 1ns/1ps
`include "sram_host_regs.svh"

module sram_host #(
    parameter int ADDR_W = `SRAM_ADDR_W,
    parameter int DATA_W = `SRAM_DATA_W
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic [ADDR_W-1:0] mem_addr,
    output logic mem_sel_n,
    output logic mem_wr_n,
    output logic mem_oe_n,
    input wire logic [DATA_W-1:0] mem_dq_in,
    output logic [DATA_W-1:0] mem_dq_out,
    output logic mem_dq_oe
);
    // cycle counts of each phase, rounded up from the slow grade
    localparam int WR_CYC = `SRAM_WRITE_CYCLES;
    localparam int RD_CYC = `SRAM_READ_CYCLES;
    localparam int TURN_CYC = `SRAM_TURN_CYCLES;
    localparam int CNT_W = 4;

    // last count of each timed phase, cut to the counter width
    localparam logic [CNT_W-1:0] RD_LAST = CNT_W'(RD_CYC + 1);
    localparam logic [CNT_W-1:0] WR_LAST = CNT_W'(WR_CYC - 1);
    localparam logic [CNT_W-1:0] TURN_LAST = CNT_W'(TURN_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    // refuse shapes the memory port cannot take
    if (ADDR_W != `SRAM_ADDR_W || DATA_W != `SRAM_DATA_W) begin : g_bad_shape
        $error("sram_host supports a 17-bit address and 8-bit data only");
    end

    // refuse phase lengths the counter cannot reach
    if (RD_CYC + 2 > 2 ** CNT_W || WR_CYC > 2 ** CNT_W
            || TURN_CYC > 2 ** CNT_W) begin : g_bad_count
        $error("sram_host phase counts do not fit the counter");
    end

    // every write and turnaround phase lasts at least one cycle
    if (WR_CYC < 1 || TURN_CYC < 1) begin : g_bad_phase
        $error("sram_host write and turnaround phases need a cycle");
    end

    // a read covers the access time and one more cycle
    if (RD_CYC < 2) begin : g_bad_read
        $error("sram_host read phase is too short");
    end

    // sequencer state and registered pins
    sram_host_pkg::state_e state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [DATA_W-1:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
    logic sel_n_r, sel_n_nxt, wr_n_r, wr_n_nxt, oe_n_r, oe_n_nxt;
    logic dq_oe_r, dq_oe_nxt, ready_r, ready_nxt, rsp_r, rsp_nxt;
    // data pin capture stages, read only through the second
    logic [DATA_W-1:0] dq_meta_r, dq_sync_r;

    // two-stage capture of the data pins
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dq_meta_r <= '0;
            dq_sync_r <= '0;
        end else begin
            dq_meta_r <= mem_dq_in;
            dq_sync_r <= dq_meta_r;
        end
    end

    // sequencer for the memory pins
    always_comb begin
        // hold everything unless a phase changes it
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        sel_n_nxt = sel_n_r;
        wr_n_nxt = wr_n_r;
        oe_n_nxt = oe_n_r;
        dq_oe_nxt = dq_oe_r;
        // handshake pulses default low
        ready_nxt = 1'b0;
        rsp_nxt = 1'b0;
        case (state_r)
            // idle: offer ready and take one request
            sram_host_pkg::ST_IDLE: begin
                ready_nxt = 1'b1;
                if (req_valid && ready_r) begin
                    ready_nxt = 1'b0;
                    addr_nxt = req_addr; // address set on the same edge as select and strobe
                    wdata_nxt = req_wdata;
                    sel_n_nxt = 1'b0;
                    cnt_nxt = '0;
                    if (req_write) begin
                        // write: select and strobe fall as the host starts driving
                        state_nxt = sram_host_pkg::ST_WRITE;
                        wr_n_nxt = 1'b0; // select and strobe fall together
                        oe_n_nxt = 1'b1;
                        dq_oe_nxt = 1'b1; // memory floats once strobe is low
                    end else begin
                        // read: output strobe low, write strobe kept high
                        state_nxt = sram_host_pkg::ST_READ;
                        wr_n_nxt = 1'b1;
                        oe_n_nxt = 1'b0;
                        dq_oe_nxt = 1'b0;
                    end
                end
            end
            sram_host_pkg::ST_READ: begin
                // wait out access time plus the pin capture stages
                cnt_nxt = cnt_r + CNT_ONE;
                if (cnt_r == RD_LAST) begin
                    rdata_nxt = dq_sync_r;
                    rsp_nxt = 1'b1;
                    sel_n_nxt = 1'b1;
                    oe_n_nxt = 1'b1;
                    cnt_nxt = '0;
                    state_nxt = sram_host_pkg::ST_TURN;
                end
            end
            sram_host_pkg::ST_WRITE: begin
                // one strobe pulse, then select and strobe rise together
                cnt_nxt = cnt_r + CNT_ONE;
                if (cnt_r == WR_LAST) begin // pulse width
                    wr_n_nxt = 1'b1; // select and strobe rise together
                    sel_n_nxt = 1'b1;
                    rsp_nxt = 1'b1;
                    state_nxt = sram_host_pkg::ST_HOLD;
                end
            end
            sram_host_pkg::ST_HOLD: begin
                // address and data held one cycle past the end of write
                dq_oe_nxt = 1'b0; // recovery and hold
                cnt_nxt = '0;
                state_nxt = sram_host_pkg::ST_TURN;
            end
            sram_host_pkg::ST_TURN: begin
                // let the memory release the bus before the next access
                cnt_nxt = cnt_r + CNT_ONE;
                if (cnt_r == TURN_LAST) begin
                    ready_nxt = 1'b1;
                    state_nxt = sram_host_pkg::ST_IDLE;
                end
            end
            // an unknown state falls back to idle
            default: state_nxt = sram_host_pkg::ST_IDLE;
        endcase
    end

    // sequencer registers
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            // strobes idle high and the host off the bus
            state_r <= sram_host_pkg::ST_IDLE;
            cnt_r <= '0;
            addr_r <= '0;
            wdata_r <= '0;
            rdata_r <= '0;
            sel_n_r <= `SRAM_PIN_IDLE;
            wr_n_r <= `SRAM_PIN_IDLE;
            oe_n_r <= `SRAM_PIN_IDLE;
            dq_oe_r <= 1'b0;
            ready_r <= 1'b0;
            rsp_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            sel_n_r <= sel_n_nxt;
            wr_n_r <= wr_n_nxt;
            oe_n_r <= oe_n_nxt;
            dq_oe_r <= dq_oe_nxt;
            ready_r <= ready_nxt;
            rsp_r <= rsp_nxt;
        end
    end

    // host side outputs straight from flip-flops
    assign req_ready = ready_r;
    assign rsp_valid = rsp_r;
    assign rsp_rdata = rdata_r;

    // memory pins straight from flip-flops
    assign mem_addr = addr_r;
    assign mem_sel_n = sel_n_r;
    assign mem_wr_n = wr_n_r;
    assign mem_oe_n = oe_n_r;
    assign mem_dq_out = wdata_r;
    assign mem_dq_oe = dq_oe_r;
endmodule : sram_host

// [sim/sram_host_chk.sv]
`timescale 1ns/1ps
module sram_host_chk #(
    parameter int ADDR_W = 17,
    parameter int DATA_W = 8
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic mem_sel_n,
    input wire logic mem_wr_n,
    input wire logic mem_oe_n,
    input wire logic [DATA_W-1:0] mem_dq_out,
    input wire logic mem_dq_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // a request is taken on this edge
    wire take = req_valid && req_ready;
    a_read_wr_high: assert property (!mem_oe_n |-> mem_wr_n)
        else $error("write strobe low in read");
    a_no_contend: assert property (mem_dq_oe |-> mem_oe_n)
        else $error("host drives while memory may");
    a_one_mode: assert property (!mem_sel_n |-> mem_wr_n != mem_oe_n)
        else $error("select without exactly one strobe");
    a_addr_first: assert property (take |=> !mem_sel_n && mem_addr == $past(req_addr))
        else $error("address not set with select");
    a_wdata_set: assert property (take && req_write |=>
        !mem_wr_n && mem_dq_oe && mem_dq_out == $past(req_wdata))
        else $error("write data not set with strobe");
    a_write_hold: assert property (!mem_wr_n |=> mem_wr_n && mem_sel_n && mem_dq_oe
        && $stable(mem_addr) && $stable(mem_dq_out))
        else $error("write end hold broken");
    a_addr_steady: assert property (!mem_sel_n && $past(!mem_sel_n) |-> $stable(mem_addr))
        else $error("address moved while selected");
    a_read_len: assert property (take && !req_write |=> (!mem_sel_n && !mem_oe_n)[*4]
        ##1 (rsp_valid && mem_sel_n && mem_oe_n))
        else $error("read cycle length wrong");
    a_write_len: assert property (take && req_write |-> ##2 rsp_valid)
        else $error("write answer late");
    a_idle_ready: assert property (req_ready |-> mem_sel_n && !mem_dq_oe)
        else $error("ready while bus busy");
endmodule : sram_host_chk

// [sim/sram_model.sv]
`timescale 1ns/1ps
module sram_model (
    input wire logic [16:0] addr,
    input wire logic sel_n,
    input wire logic wr_n,
    input wire logic oe_n,
    input wire logic [7:0] host_dq,
    input wire logic host_oe,
    output logic [7:0] dq
);
    logic [7:0] mem [0:131071];
    logic [7:0] last = 8'h00;
    logic [7:0] rd_byte = 8'h00;
    wire drv = !sel_n && wr_n && !oe_n;
    wire win_n = sel_n | wr_n;
    // store at the end of the select and strobe overlap
    always @(posedge win_n) if (host_oe === 1'b1) mem[addr] <= host_dq;
    // the old byte stays 2 ns after the address or select moves
    always @(addr or drv) rd_byte <= #2 mem[addr];
    // remember the last byte so a released bus does not keep it
    always @(negedge drv) last = rd_byte;
    // resolve the shared bus
    always @* begin
        if (host_oe === 1'b1) dq = host_dq;
        else if (drv) dq = rd_byte;
        else dq = ~last;
    end
endmodule : sram_model

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [16:0] req_addr = 17'h00000;
    logic [7:0] req_wdata = 8'h00;
    logic req_ready, rsp_valid, mem_sel_n, mem_wr_n, mem_oe_n, mem_dq_oe;
    logic [7:0] rsp_rdata, mem_dq_out, dq;
    logic [16:0] mem_addr;
    int n_errors = 0;
    int compares = 0;
    always #5 ref_clk = ~ref_clk;
    sram_host i_sram_host (.ref_clk(ref_clk), .sys_rst(sys_rst), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .mem_addr(mem_addr), .mem_sel_n(mem_sel_n), .mem_wr_n(mem_wr_n), .mem_oe_n(mem_oe_n),
        .mem_dq_in(dq), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe));
    sram_model i_sram_model (.addr(mem_addr), .sel_n(mem_sel_n), .wr_n(mem_wr_n),
        .oe_n(mem_oe_n), .host_dq(mem_dq_out), .host_oe(mem_dq_oe), .dq(dq));
    task automatic summarize;
        $display("%0d compares, %0d errors", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    // one request, waits for take and answer; called at a falling edge
    task automatic xfer(input logic w, input logic [16:0] a, input logic [7:0] d);
        int n = 0;
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        while (req_ready !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
        @(negedge ref_clk);
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 40) begin
            n_errors++;
            summarize();
        end
    endtask : xfer
    task automatic t_reset;
        chk(17'({mem_sel_n, mem_wr_n, mem_oe_n, mem_dq_oe, req_ready}), 17'h0001C);
        $display("t_reset done");
    endtask : t_reset
    // corner addresses written, then read back newest first
    task automatic t_fill;
        logic [16:0] a [4] = '{17'h00000, 17'h1FFFF, 17'h0AAAA, 17'h15555};
        for (int i = 0; i < 4; i++) xfer(1'b1, a[i], a[i][7:0] ^ 8'h5A);
        for (int i = 3; i >= 0; i--) begin
            xfer(1'b0, a[i], 8'h00);
            chk(17'(rsp_rdata), 17'(a[i][7:0] ^ 8'h5A));
        end
        $display("t_fill done");
    endtask : t_fill
    // a second write replaces the first and leaves others alone
    task automatic t_overwrite;
        xfer(1'b1, 17'h00100, 8'h11);
        xfer(1'b1, 17'h00100, 8'hEE);
        xfer(1'b0, 17'h00100, 8'h00);
        chk(17'(rsp_rdata), 17'h000EE);
        xfer(1'b0, 17'h00000, 8'h00);
        chk(17'(rsp_rdata), 17'h0005A);
        $display("t_overwrite done");
    endtask : t_overwrite
    initial begin
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        t_reset();
        sys_rst = 1'b0;
        t_fill();
        t_overwrite();
        summarize();
    end
endmodule : tb
bind sram_host sram_host_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_sram_host_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .mem_addr(mem_addr), .mem_sel_n(mem_sel_n),
    .mem_wr_n(mem_wr_n), .mem_oe_n(mem_oe_n), .mem_dq_out(mem_dq_out),
    .mem_dq_oe(mem_dq_oe));
